/* File: hdl/gpx_external_irq_input_det.sv */
/*
  filter and trigger detector for the external interrupt inputs.
  assumes inputs already pass a two-stage synchroniser in the top.
*/
`timescale 1ns/10ps
module gpx_external_irq_input_det #(
  parameter int N = 19,
  parameter logic [18:0] FILT = 19'h7f800
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // synchronised levels and settings
  input wire logic [N-1:0] lvl,
  input wire logic [3*N-1:0] trig,
  input wire logic [N-1:0] flt_en,
  input wire logic [7:0] flt_len,
  // trigger condition met this cycle
  output logic [N-1:0] hit
);
  // refuse more inputs than the select words can serve
  if (N > 19) begin : g_bad_n
    $error("gpx_external_irq_input_det: N above 19");
  end
  logic [N-1:0] flt_ff, nxt_flt, prev_ff, nxt_prev;
  logic [7:0] cnt_ff [N], nxt_cnt [N];
  // filter: follow input once it differs for flt_len+1 cycles
  always_comb begin
    for (int i = 0; i < N; i++) begin
      nxt_cnt[i] = 8'h00;
      nxt_flt[i] = lvl[i];
      if (FILT[i] && flt_en[i]) begin
        nxt_flt[i] = flt_ff[i];
        if (lvl[i] != flt_ff[i]) begin
          nxt_cnt[i] = cnt_ff[i] + 8'h01;
          if (cnt_ff[i] >= flt_len) begin
            nxt_flt[i] = lvl[i];
            nxt_cnt[i] = 8'h00;
          end
        end
      end
    end
    nxt_prev = flt_ff;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flt_ff <= '0;
      prev_ff <= '0;
      for (int i = 0; i < N; i++) cnt_ff[i] <= 8'h00;
    end else if (ce) begin
      flt_ff <= nxt_flt;
      prev_ff <= nxt_prev;
      cnt_ff <= nxt_cnt;
    end
  end
  // trigger decode on filtered level
  always_comb begin
    for (int i = 0; i < N; i++) begin
      case (trig[3*i+:3])
        3'h0: hit[i] = ~flt_ff[i];
        3'h1: hit[i] = flt_ff[i];
        3'h2, 3'h3: hit[i] = prev_ff[i] & ~flt_ff[i];
        3'h4, 3'h5: hit[i] = ~prev_ff[i] & flt_ff[i];
        default: hit[i] = prev_ff[i] ^ flt_ff[i];
      endcase
    end
  end
endmodule

/* File: hdl/gpx_top.sv */
/*
  32-pin function mux with external interrupts, wake-up, pull-up
  control, sleep pin state and always-on status.
  assumes peripherals run on CLOCK; pins and battery fault are async.
*/
`timescale 1ns/10ps
module gpx_top #(
  parameter int PERI_W = 32
) (
  // clock, reset, enable
  input wire logic CLOCK,
  input wire logic SYS_RST,
  input wire logic CE,
  // register port
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  // pins
  input wire logic [31:0] PIN_IN,
  output logic [31:0] PIN_OUT,
  output logic [31:0] PIN_OE,
  output logic [31:0] PIN_PULLUP_EN,
  output logic [PERI_W-1:0] PERI_PULLUP_EN,
  // alternate peripheral functions
  input wire logic [31:0] ALT1_OUT,
  input wire logic [31:0] ALT1_OE,
  input wire logic [31:0] ALT2_OUT,
  input wire logic [31:0] ALT2_OE,
  output logic [31:0] ALT1_IN,
  output logic [31:0] ALT2_IN,
  // power management
  input wire logic SLEEP,
  input wire logic BATTERY_FAULT_LOW,
  input wire logic CLOCK_ALARM_IRQ,
  input wire logic [1:0] RESET_CAUSE,
  output logic WAKE,
  output logic IRQ
);
  if (PERI_W < 1 || PERI_W > 32) begin : g_bad_peri_w
    $error("gpx_top: PERI_W 1..32");
  end

  logic [gpx_pkg::W_FSEL_U-1:0] fsu_ff, nxt_fsu;
  logic [gpx_pkg::W_FSEL_M-1:0] fsm_ff, nxt_fsm;
  logic [gpx_pkg::W_FSEL_L-1:0] fsl_ff, nxt_fsl;
  logic [31:0] dat_ff, nxt_dat, pud_ff, nxt_pud;
  logic [PERI_W-1:0] ppud_ff, nxt_ppud;
  logic [29:0] trl_ff, nxt_trl;
  logic [26:0] trh_ff, nxt_trh;
  logic [15:0] flt_ff, nxt_flt;
  logic [18:0] msk_ff, nxt_msk, pnd_ff, nxt_pnd;
  logic [1:0] cause_ff, nxt_cause;
  logic caught_ff, nxt_caught, bat_ff, nxt_bat;
  logic [31:0] sdat_ff, nxt_sdat, soe_ff, nxt_soe, spud_ff, nxt_spud;
  logic [31:0] rd_ff, nxt_rd;
  logic [31:0] pin_s1_ff, pin_s2_ff;
  logic bf_s1_ff, bf_s2_ff;
  logic [31:0] po_ff, nxt_po, poe_ff, nxt_poe, ppu_ff, nxt_ppu;
  logic [31:0] a1_ff, nxt_a1, a2_ff, nxt_a2;
  logic [PERI_W-1:0] pepu_ff, nxt_pepu;
  logic wake_ff, nxt_wake, irq_ff, nxt_irq;
  logic [63:0] fsel;
  logic [18:0] hit, ei_mode, blk, ev;
  logic alarm_prev_ff, nxt_alarm_prev, alarm_ev;

  // function select field of one pin out of the joined selects
  function automatic logic [1:0] fs_of(input logic [63:0] f,
                                       input int p);
    fs_of = f[2*p+:2];
  endfunction

  // write strobe for one register
  function automatic logic hit_wr(input logic w, input logic [7:0] a,
                                  input logic [7:0] o);
    hit_wr = w && (a == o);
  endfunction

  assign fsel = {fsu_ff, fsm_ff, fsl_ff};

  // two-stage synchronisers for pins and battery fault
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      pin_s1_ff <= 32'h0000_0000;
      pin_s2_ff <= 32'h0000_0000;
      bf_s1_ff <= 1'b1;
      bf_s2_ff <= 1'b1;
    end else if (CE) begin
      pin_s1_ff <= PIN_IN;
      pin_s2_ff <= pin_s1_ff;
      bf_s1_ff <= BATTERY_FAULT_LOW;
      bf_s2_ff <= bf_s1_ff;
    end
  end

  gpx_external_irq_input_det #(
    .N(gpx_pkg::NEI),
    .FILT(gpx_pkg::EI_FILT)
  ) u_det (
    .clk(CLOCK),
    .rst(SYS_RST),
    .ce(CE),
    .lvl(pin_s2_ff[18:0]),
    .trig({trh_ff, trl_ff}),
    .flt_en({flt_ff[7:0], 11'h000}),
    .flt_len(flt_ff[15:8]),
    .hit(hit)
  );

  // interrupt mode per input, and battery-fault blocking in sleep
  always_comb begin
    for (int e = 0; e < gpx_pkg::NEI; e++) begin
      ei_mode[e] = gpx_pkg::EI_PINS[e] &&
                   (fs_of(fsel, e) == gpx_pkg::FS_ALT1);
    end
    blk = (SLEEP && !bf_s2_ff) ? gpx_pkg::EI_WAKE : 19'h00000;
    ev = hit & ei_mode & ~blk;
    alarm_ev = CLOCK_ALARM_IRQ && !alarm_prev_ff && SLEEP &&
               bf_s2_ff;
    nxt_alarm_prev = CLOCK_ALARM_IRQ;
  end

  // register next values, pending set wins over clear
  always_comb begin
    nxt_fsu = fsu_ff;
    nxt_fsm = fsm_ff;
    nxt_fsl = fsl_ff;
    nxt_dat = dat_ff;
    nxt_pud = pud_ff;
    nxt_ppud = ppud_ff;
    nxt_trl = trl_ff;
    nxt_trh = trh_ff;
    nxt_flt = flt_ff;
    nxt_msk = msk_ff;
    nxt_pnd = pnd_ff;
    nxt_sdat = sdat_ff;
    nxt_soe = soe_ff;
    nxt_spud = spud_ff;
    nxt_bat = bat_ff;
    if (hit_wr(WR, ADDR, gpx_pkg::OFS_FSEL_U))
      nxt_fsu = WDATA[gpx_pkg::W_FSEL_U-1:0];
    if (hit_wr(WR, ADDR, gpx_pkg::OFS_FSEL_M))
      nxt_fsm = WDATA[gpx_pkg::W_FSEL_M-1:0];
    if (hit_wr(WR, ADDR, gpx_pkg::OFS_FSEL_L))
      nxt_fsl = WDATA[gpx_pkg::W_FSEL_L-1:0];
    if (hit_wr(WR, ADDR, gpx_pkg::OFS_DATA)) nxt_dat = WDATA;
    if (hit_wr(WR, ADDR, gpx_pkg::OFS_PUD)) nxt_pud = WDATA;
    if (hit_wr(WR, ADDR, gpx_pkg::OFS_PERI_PUD))
      nxt_ppud = WDATA[PERI_W-1:0];
    if (hit_wr(WR, ADDR, gpx_pkg::OFS_TRIG_LO)) nxt_trl = WDATA[29:0];
    if (hit_wr(WR, ADDR, gpx_pkg::OFS_TRIG_HI)) nxt_trh = WDATA[26:0];
    if (hit_wr(WR, ADDR, gpx_pkg::OFS_FILT)) nxt_flt = WDATA[15:0];
    if (hit_wr(WR, ADDR, gpx_pkg::OFS_MASK)) nxt_msk = WDATA[18:0];
    if (hit_wr(WR, ADDR, gpx_pkg::OFS_SLP_DAT)) nxt_sdat = WDATA;
    if (hit_wr(WR, ADDR, gpx_pkg::OFS_SLP_OE)) nxt_soe = WDATA;
    if (hit_wr(WR, ADDR, gpx_pkg::OFS_SLP_PUD)) nxt_spud = WDATA;
    if (hit_wr(WR, ADDR, gpx_pkg::OFS_PEND))
      nxt_pnd = pnd_ff & ~WDATA[18:0];
    nxt_pnd = nxt_pnd | ev;
    if (alarm_ev) nxt_pnd[gpx_pkg::ALARM_BIT] = 1'b1;
    if (hit_wr(WR, ADDR, gpx_pkg::OFS_ALIVE) &&
        WDATA[gpx_pkg::ALIVE_BAT_POS])
      nxt_bat = 1'b0;
    if (!bf_s2_ff) nxt_bat = 1'b1;
  end

  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      fsu_ff <= '0;
      fsm_ff <= '0;
      fsl_ff <= '0;
      dat_ff <= gpx_pkg::RST_ZERO;
      pud_ff <= gpx_pkg::RST_ZERO;
      ppud_ff <= '0;
      trl_ff <= '0;
      trh_ff <= '0;
      flt_ff <= {gpx_pkg::RST_FILT_LEN, 8'h00};
      msk_ff <= gpx_pkg::RST_MASK[18:0];
      pnd_ff <= '0;
      sdat_ff <= gpx_pkg::RST_ZERO;
      soe_ff <= gpx_pkg::RST_ZERO;
      spud_ff <= gpx_pkg::RST_ZERO;
      bat_ff <= 1'b0;
      alarm_prev_ff <= 1'b0;
    end else if (CE) begin
      fsu_ff <= nxt_fsu;
      fsm_ff <= nxt_fsm;
      fsl_ff <= nxt_fsl;
      dat_ff <= nxt_dat;
      pud_ff <= nxt_pud;
      ppud_ff <= nxt_ppud;
      trl_ff <= nxt_trl;
      trh_ff <= nxt_trh;
      flt_ff <= nxt_flt;
      msk_ff <= nxt_msk;
      pnd_ff <= nxt_pnd;
      sdat_ff <= nxt_sdat;
      soe_ff <= nxt_soe;
      spud_ff <= nxt_spud;
      bat_ff <= nxt_bat;
      alarm_prev_ff <= nxt_alarm_prev;
    end
  end

  // reset cause caught once after reset release
  always_comb begin
    nxt_caught = 1'b1;
    nxt_cause = caught_ff ? cause_ff : RESET_CAUSE;
  end

  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      caught_ff <= 1'b0;
      cause_ff <= 2'h0;
    end else if (CE) begin
      caught_ff <= nxt_caught;
      cause_ff <= nxt_cause;
    end
  end

  // pin mux, pull-ups, peripheral routing, wake and request
  always_comb begin
    for (int p = 0; p < 32; p++) begin
      nxt_po[p] = 1'b0;
      nxt_poe[p] = 1'b0;
      nxt_a1[p] = 1'b0;
      nxt_a2[p] = 1'b0;
      case (fs_of(fsel, p))
        gpx_pkg::FS_OUT: begin
          nxt_po[p] = dat_ff[p];
          nxt_poe[p] = 1'b1;
        end
        gpx_pkg::FS_ALT1: begin
          nxt_a1[p] = pin_s2_ff[p];
          if (!(p < gpx_pkg::NEI && gpx_pkg::EI_PINS[p])) begin
            nxt_po[p] = ALT1_OUT[p];
            nxt_poe[p] = ALT1_OE[p];
          end
        end
        gpx_pkg::FS_ALT2: begin
          nxt_a2[p] = pin_s2_ff[p];
          nxt_po[p] = ALT2_OUT[p];
          nxt_poe[p] = ALT2_OE[p];
        end
        default: begin
          nxt_po[p] = 1'b0; // plain input
        end
      endcase
    end
    nxt_ppu = ~pud_ff;
    nxt_pepu = ~ppud_ff;
    if (SLEEP) begin
      nxt_po = sdat_ff;
      nxt_poe = soe_ff;
      nxt_ppu = ~spud_ff;
    end
    nxt_wake = SLEEP && ((|(ev & gpx_pkg::EI_WAKE)) || alarm_ev);
    nxt_irq = |(nxt_pnd & ~msk_ff & ei_mode);
  end

  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      po_ff <= 32'h0000_0000;
      poe_ff <= 32'h0000_0000;
      ppu_ff <= 32'hffff_ffff;
      pepu_ff <= '1;
      a1_ff <= 32'h0000_0000;
      a2_ff <= 32'h0000_0000;
      wake_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else if (CE) begin
      po_ff <= nxt_po;
      poe_ff <= nxt_poe;
      ppu_ff <= nxt_ppu;
      pepu_ff <= nxt_pepu;
      a1_ff <= nxt_a1;
      a2_ff <= nxt_a2;
      wake_ff <= nxt_wake;
      irq_ff <= nxt_irq;
    end
  end

  // read mux, answer one cycle after the strobe
  always_comb begin
    nxt_rd = 32'h0000_0000;
    if (RD) begin
      case (ADDR)
        gpx_pkg::OFS_FSEL_U: nxt_rd = {6'h00, fsu_ff};
        gpx_pkg::OFS_FSEL_M: nxt_rd = {16'h0000, fsm_ff};
        gpx_pkg::OFS_FSEL_L: nxt_rd = {10'h000, fsl_ff};
        gpx_pkg::OFS_DATA: begin
          for (int p = 0; p < 32; p++) begin
            case (fs_of(fsel, p))
              gpx_pkg::FS_IN: nxt_rd[p] = pin_s2_ff[p];
              gpx_pkg::FS_OUT: nxt_rd[p] = dat_ff[p];
              default: nxt_rd[p] = 1'b0;
            endcase
          end
        end
        gpx_pkg::OFS_PUD: nxt_rd = pud_ff;
        gpx_pkg::OFS_PERI_PUD: nxt_rd[PERI_W-1:0] = ppud_ff;
        gpx_pkg::OFS_TRIG_LO: nxt_rd = {2'h0, trl_ff};
        gpx_pkg::OFS_TRIG_HI: nxt_rd = {5'h00, trh_ff};
        gpx_pkg::OFS_FILT: nxt_rd = {16'h0000, flt_ff};
        gpx_pkg::OFS_MASK: nxt_rd = {13'h0000, msk_ff};
        gpx_pkg::OFS_PEND: nxt_rd = {13'h0000, pnd_ff};
        gpx_pkg::OFS_ALIVE: nxt_rd = {29'h0, bat_ff, cause_ff};
        gpx_pkg::OFS_SLP_DAT: nxt_rd = sdat_ff;
        gpx_pkg::OFS_SLP_OE: nxt_rd = soe_ff;
        gpx_pkg::OFS_SLP_PUD: nxt_rd = spud_ff;
        default: nxt_rd = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) rd_ff <= 32'h0000_0000;
    else if (CE) rd_ff <= nxt_rd;
  end

  // outputs straight from flip-flops
  assign RDATA = rd_ff;
  assign PIN_OUT = po_ff;
  assign PIN_OE = poe_ff;
  assign PIN_PULLUP_EN = ppu_ff;
  assign PERI_PULLUP_EN = pepu_ff;
  assign ALT1_IN = a1_ff;
  assign ALT2_IN = a2_ff;
  assign WAKE = wake_ff;
  assign IRQ = irq_ff;
endmodule

/* File: inc/gpx_pkg.sv */
/*
  constants of the pin mux and external interrupt block: register
  offsets, field layouts, reset values, trigger codes.
  assumes a byte-addressed plain register port, 32-bit data.
*/
// Notes on behaviour
// - 32 pins, each software input, output, alternate
// - per-pin select routes pin to one function
// - wake pins in interrupt mode, mask ignored
// - output drives data bit; input reads pin
// - pull-up bit 0 enables, 1 disables
// - enabled pull-up works in every pin function
// - 18 inputs: low, high, fall, rise, both
// - request only when interrupt mode and unmasked
// - pending sets in interrupt mode, even masked
// - eight inputs filtered before trigger detection
// - only inputs 0 to 9 wake from sleep
// - battery fault in sleep blocks wake, pending
// - pending records wake source, alarm bit too
// - peripheral pull-up bit 0 enables, 1 disables
// - status shows reset cause and battery fault
// - separate pin state settings used in sleep
// - select 00 in, 01 out, 10/11 alternates
// - alternate function pin reads undefined value
package gpx_pkg;
  localparam int NPIN = 32;
  localparam int NEI = 19; // index 10 is the alarm wake bit
  localparam logic [7:0] OFS_FSEL_U = 8'h00;
  localparam logic [7:0] OFS_FSEL_M = 8'h04;
  localparam logic [7:0] OFS_FSEL_L = 8'h08;
  localparam logic [7:0] OFS_DATA = 8'h0c;
  localparam logic [7:0] OFS_PUD = 8'h10;
  localparam logic [7:0] OFS_PERI_PUD = 8'h18;
  localparam logic [7:0] OFS_TRIG_LO = 8'h20;
  localparam logic [7:0] OFS_TRIG_HI = 8'h24;
  localparam logic [7:0] OFS_FILT = 8'h28;
  localparam logic [7:0] OFS_MASK = 8'h2c;
  localparam logic [7:0] OFS_PEND = 8'h30;
  localparam logic [7:0] OFS_ALIVE = 8'h34;
  localparam logic [7:0] OFS_SLP_DAT = 8'h38;
  localparam logic [7:0] OFS_SLP_OE = 8'h3c;
  localparam logic [7:0] OFS_SLP_PUD = 8'h40;
  // field widths of the three select registers
  localparam int W_FSEL_U = 26;
  localparam int W_FSEL_M = 16;
  localparam int W_FSEL_L = 22;
  localparam int TRIG_LO_N = 10; // inputs 0..9 in low trigger word
  localparam int FILT_LEN_POS = 8;
  localparam int ALIVE_BAT_POS = 2;
  // which indices are real pins, filtered inputs, wake sources
  localparam logic [18:0] EI_PINS = 19'h7fbff;
  localparam logic [18:0] EI_FILT = 19'h7f800;
  localparam logic [18:0] EI_WAKE = 19'h003ff;
  localparam int ALARM_BIT = 10;
  // reset values
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
  localparam logic [31:0] RST_MASK = 32'h0007_ffff;
  localparam logic [7:0] RST_FILT_LEN = 8'h04;
  // pin function select codes
  localparam logic [1:0] FS_IN = 2'h0;
  localparam logic [1:0] FS_OUT = 2'h1;
  localparam logic [1:0] FS_ALT1 = 2'h2;
  localparam logic [1:0] FS_ALT2 = 2'h3;
  // trigger codes: 000 low, 001 high, 01x fall, 10x rise, 11x both
  localparam logic [2:0] TR_LOW = 3'h0;
  localparam logic [2:0] TR_HIGH = 3'h1;
endpackage

/* File: testbench/gpio_pin_mux_ext_interrupt_tb.sv */
/*
  bench for the pin mux block with expectations kept in the bench.
  assumes the checker binds itself from its own file.
*/
`timescale 1ns/10ps
module gpio_pin_mux_ext_interrupt_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic sleep = 1'b0;
  logic batt_n = 1'b1;
  logic alarm = 1'b0;
  logic ce = 1'b1;
  logic wake, irq;
  logic [1:0] cause = 2'h1;
  logic [7:0] addr = 8'h0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] a1o = 32'h0, a1e = 32'h0, a2o = 32'h0, a2e = 32'h0;
  logic [31:0] ext_en = 32'hffffffff, ext_val = 32'h0;
  logic [31:0] rdata, pin_in, pin_out, pin_oe, pull_en, peri_pull;
  logic [31:0] a1_in, a2_in, v, m_dat, m_pud, om, im, am, bm;
  logic [63:0] m_fs;
  logic [2:0] c;
  integer seed = 97819;
  integer mismatches = 0;
  integer total_checks = 0;
  integer wakes = 0;
  // 25 MHz clock
  always #20 clk = ~clk;
  // count clock edges with wake high
  always @(posedge clk) begin
    if (wake === 1'b1) begin
      wakes++;
    end
  end
  gpx_top #(.PERI_W(32)) dut (
    .CLOCK(clk), .SYS_RST(rst), .CE(ce), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .RDATA(rdata), .PIN_IN(pin_in), .PIN_OUT(pin_out),
    .PIN_OE(pin_oe), .PIN_PULLUP_EN(pull_en), .PERI_PULLUP_EN(peri_pull),
    .ALT1_OUT(a1o), .ALT1_OE(a1e), .ALT2_OUT(a2o), .ALT2_OE(a2e),
    .ALT1_IN(a1_in), .ALT2_IN(a2_in), .SLEEP(sleep),
    .BATTERY_FAULT_LOW(batt_n), .CLOCK_ALARM_IRQ(alarm),
    .RESET_CAUSE(cause), .WAKE(wake), .IRQ(irq)
  );
  gpx_pin_model pins (
    .clk(clk), .pin_out(pin_out), .pin_oe(pin_oe), .pull_en(pull_en),
    .ext_en(ext_en), .ext_val(ext_val), .lvl(pin_in)
  );
  // bus cycles and comparison
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    rd_reg(a, v);
    chk(v, e);
  endtask
  task automatic pend_chk(input logic e);
    rd_reg(gpx_pkg::OFS_PEND, v);
    chk(32'(v[3]), 32'(e));
    chk(32'(irq), 32'(e));
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // cut a hang short
  initial begin
    #2000000;
    mismatches++;
    conclude();
  end
  // main sequence
  initial begin
    cyc(20);
    rst <= 1'b0;
    cyc(2);
    chk(peri_pull, 32'hffffffff);
    rd_chk(gpx_pkg::OFS_MASK, gpx_pkg::RST_MASK);
    rd_chk(gpx_pkg::OFS_ALIVE, {30'h0, cause});
    rd_chk(8'h14, 32'h0);
    // a write while the clock enable is low must not land
    cyc(1);
    ce <= 1'b0;
    wr_reg(gpx_pkg::OFS_SLP_DAT, 32'h5a5a_5a5a);
    ce <= 1'b1;
    rd_chk(gpx_pkg::OFS_SLP_DAT, 32'h0);
    $display("test reset done");
    ext_en <= 32'h0;
    repeat (3) begin
      m_pud = $random(seed);
      wr_reg(gpx_pkg::OFS_PUD, m_pud);
      wr_reg(gpx_pkg::OFS_PERI_PUD, ~m_pud);
      cyc(4);
      chk(peri_pull, m_pud);
      rd_reg(gpx_pkg::OFS_DATA, v);
      chk(v & ~m_pud, ~m_pud);
    end
    $display("test pull-up done");
    wr_reg(gpx_pkg::OFS_MASK, gpx_pkg::RST_MASK);
    ext_en <= 32'hffffffff;
    repeat (4) begin
      m_fs = {$random(seed), $random(seed)};
      m_dat = $random(seed);
      wr_reg(gpx_pkg::OFS_FSEL_L, 32'(m_fs[21:0]));
      wr_reg(gpx_pkg::OFS_FSEL_M, 32'(m_fs[37:22]));
      wr_reg(gpx_pkg::OFS_FSEL_U, 32'(m_fs[63:38]));
      wr_reg(gpx_pkg::OFS_DATA, m_dat);
      ext_val <= $random(seed);
      a2o <= $random(seed);
      a2e <= $random(seed);
      a1o <= $random(seed);
      a1e <= $random(seed);
      cyc(5);
      for (int p = 0; p < 32; p++) begin
        om[p] = m_fs[2*p +: 2] == gpx_pkg::FS_OUT;
        im[p] = m_fs[2*p +: 2] == gpx_pkg::FS_IN;
        am[p] = m_fs[2*p +: 2] == gpx_pkg::FS_ALT2;
        bm[p] = m_fs[2*p +: 2] == gpx_pkg::FS_ALT1;
      end
      am = am & ~32'h3c01;
      rd_reg(gpx_pkg::OFS_DATA, v);
      chk(v & (om | im), m_dat & om | ext_val & im);
      chk(pin_oe & (om | im), om);
      chk(pin_out & om, m_dat & om);
      chk(a2_in & ~32'h3c01, pin_in & am);
      chk(a1_in, pin_in & bm);
      chk(pin_oe & am, a2e & am);
      chk(pin_out & am, a2o & am);
      chk(pull_en, ~m_pud);
    end
    $display("test pin functions done");
    wr_reg(gpx_pkg::OFS_FSEL_L, 32'h80);
    wr_reg(gpx_pkg::OFS_FSEL_M, 32'h0);
    wr_reg(gpx_pkg::OFS_FSEL_U, 32'h0);
    wr_reg(gpx_pkg::OFS_MASK, 32'h7fff7);
    for (int k = 0; k < 8; k++) begin
      c = 3'(k);
      ext_val <= 32'h0;
      wr_reg(gpx_pkg::OFS_TRIG_LO, 32'(c) << 9);
      cyc(6);
      wr_reg(gpx_pkg::OFS_PEND, 32'h8);
      cyc(6);
      pend_chk(c == 0);
      ext_val <= 32'h8;
      cyc(6);
      pend_chk(c <= 1 || c >= 4);
      wr_reg(gpx_pkg::OFS_PEND, 32'h8);
      ext_val <= 32'h0;
      cyc(6);
      pend_chk(c <= 3 || c >= 6);
    end
    wr_reg(gpx_pkg::OFS_MASK, gpx_pkg::RST_MASK);
    wr_reg(gpx_pkg::OFS_TRIG_LO, 32'h800);
    wr_reg(gpx_pkg::OFS_PEND, 32'h8);
    ext_val <= 32'h8;
    cyc(6);
    rd_reg(gpx_pkg::OFS_PEND, v);
    chk(32'(v[3]), 32'h1);
    chk(32'(irq), 32'h0);
    wr_reg(gpx_pkg::OFS_FSEL_L, 32'h0);
    ext_val <= 32'h0;
    wr_reg(gpx_pkg::OFS_PEND, 32'h8);
    ext_val <= 32'h8;
    cyc(6);
    rd_reg(gpx_pkg::OFS_PEND, v);
    chk(32'(v[3]), 32'h0);
    $display("test triggers done");
    wr_reg(gpx_pkg::OFS_FSEL_L, 32'h80);
    wr_reg(gpx_pkg::OFS_FSEL_M, 32'h2);
    wr_reg(gpx_pkg::OFS_TRIG_HI, 32'h20);
    // filtered input 11, length 4: short pulse dropped, long one kept
    wr_reg(gpx_pkg::OFS_FILT, 32'h0401);
    wr_reg(gpx_pkg::OFS_PEND, 32'h800);
    ext_val <= 32'h808;
    cyc(3);
    ext_val <= 32'h8;
    cyc(8);
    rd_reg(gpx_pkg::OFS_PEND, v);
    chk(32'(v[11]), 32'h0);
    ext_val <= 32'h808;
    cyc(10);
    rd_reg(gpx_pkg::OFS_PEND, v);
    chk(32'(v[11]), 32'h1);
    $display("test filter done");
    ext_val <= 32'h0;
    cyc(6);
    wr_reg(gpx_pkg::OFS_PEND, 32'hffffffff);
    sleep <= 1'b1;
    cyc(4);
    chk(pull_en, 32'hffffffff);
    wakes = 0;
    ext_val <= 32'h800;
    cyc(8);
    chk(32'(wakes), 32'h0);
    ext_val <= 32'h808;
    cyc(8);
    chk(32'(wakes), 32'h1);
    alarm <= 1'b1;
    cyc(8);
    alarm <= 1'b0;
    chk(32'(wakes), 32'h2);
    rd_reg(gpx_pkg::OFS_PEND, v);
    chk(32'({v[10], v[3]}), 32'h3);
    batt_n <= 1'b0;
    ext_val <= 32'h0;
    cyc(8);
    wr_reg(gpx_pkg::OFS_PEND, 32'h408);
    wakes = 0;
    ext_val <= 32'h8;
    alarm <= 1'b1;
    cyc(8);
    alarm <= 1'b0;
    chk(32'(wakes), 32'h0);
    rd_reg(gpx_pkg::OFS_PEND, v);
    chk(32'({v[10], v[3]}), 32'h0);
    rd_reg(gpx_pkg::OFS_ALIVE, v);
    chk(32'(v[2]), 32'h1);
    cyc(1);
    sleep <= 1'b0;
    batt_n <= 1'b1;
    cyc(8);
    $display("test sleep done");
    conclude();
  end
endmodule

/* File: testbench/gpx_pin_model.sv */
/*
  outside of the pins: block drive, an outside driver, pull-ups.
  assumes one clock; undriven unpulled lines flip every cycle.
*/
`timescale 1ns/10ps
module gpx_pin_model (
  // clock
  input wire logic clk,
  // block side
  input wire logic [31:0] pin_out,
  input wire logic [31:0] pin_oe,
  input wire logic [31:0] pull_en,
  // outside driver
  input wire logic [31:0] ext_en,
  input wire logic [31:0] ext_val,
  // resolved level
  output logic [31:0] lvl
);
  logic [31:0] float_ff = 32'h0;
  // floating lines keep no stale value
  always_ff @(posedge clk) begin
    float_ff <= ~float_ff;
  end
  // block drive wins, then the outside, then the pull-up
  always_comb begin
    lvl = pin_oe & pin_out | ~pin_oe & ext_en & ext_val
      | ~pin_oe & ~ext_en & (pull_en | float_ff);
  end
endmodule

/* File: testbench/gpx_top_asserts.sv */
/*
  port-level checker for the pin mux block, bound into the top.
  assumes CE drops only while no read data stands.
*/
`timescale 1ns/10ps
module gpx_top_chk #(
  parameter int PERI_W = 32
) (
  // clock and reset
  input wire logic CLOCK,
  input wire logic SYS_RST,
  // register port
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [31:0] RDATA,
  // pins and power
  input wire logic [31:0] PIN_OE,
  input wire logic [31:0] PIN_PULLUP_EN,
  input wire logic [PERI_W-1:0] PERI_PULLUP_EN,
  input wire logic SLEEP,
  input wire logic BATTERY_FAULT_LOW,
  input wire logic WAKE,
  input wire logic IRQ
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);
  logic rd_ff;
  // read strobe of the previous edge
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      rd_ff <= 1'b0;
    end else begin
      rd_ff <= RD;
    end
  end
  a_rdata_idle: assert property (!rd_ff |-> RDATA == 32'h0)
    else $error("read data not zero outside a read");
  a_hole_reads_zero: assert property (
    RD && ADDR == 8'h14 |=> RDATA == 32'h0)
    else $error("unmapped read not zero");
  a_mask_quiets_irq: assert property (
    WR && ADDR == gpx_pkg::OFS_MASK && WDATA == gpx_pkg::RST_MASK
    |-> ##2 !IRQ)
    else $error("irq high after masking all");
  a_pullup_follows: assert property (
    WR && ADDR == gpx_pkg::OFS_PUD && !SLEEP ##1 !SLEEP
    |-> ##1 PIN_PULLUP_EN == ~$past(WDATA, 2))
    else $error("pin pull-up not inverse of written bits");
  a_peri_pullup: assert property (
    WR && ADDR == gpx_pkg::OFS_PERI_PUD && !SLEEP ##1 !SLEEP
    |-> ##1 PERI_PULLUP_EN == PERI_W'(~$past(WDATA, 2)))
    else $error("peripheral pull-up not inverse of written bits");
  a_reset_values: assert property (
    $fell(SYS_RST) |-> PIN_OE == 32'h0 && !IRQ && !WAKE
    && PIN_PULLUP_EN == 32'hffffffff)
    else $error("outputs wrong after reset");
  a_no_wake_awake: assert property ((!SLEEP)[*6] |-> !WAKE)
    else $error("wake while awake");
  a_fault_blocks_wake: assert property (
    (SLEEP && !BATTERY_FAULT_LOW)[*6] |-> !WAKE)
    else $error("wake during battery fault");
  // main scenarios reached
  c_irq: cover property ($rose(IRQ));
  c_wake: cover property (WAKE);
  c_read: cover property (rd_ff && RDATA != 32'h0);
endmodule

bind gpx_top gpx_top_chk #(.PERI_W(PERI_W)) u_chk (
  .CLOCK(CLOCK), .SYS_RST(SYS_RST), .ADDR(ADDR), .WDATA(WDATA),
  .WR(WR), .RD(RD), .RDATA(RDATA), .PIN_OE(PIN_OE),
  .PIN_PULLUP_EN(PIN_PULLUP_EN), .PERI_PULLUP_EN(PERI_PULLUP_EN),
  .SLEEP(SLEEP), .BATTERY_FAULT_LOW(BATTERY_FAULT_LOW),
  .WAKE(WAKE), .IRQ(IRQ)
);
